// file: src/igs_regs.svh
`ifndef IGS_REGS_SVH
`define IGS_REGS_SVH

// Byte addresses on the register bus
`define IGS_OFS_SRC_MASK 8'hA8
`define IGS_OFS_PWR_CTRL 8'hAC
`define IGS_OFS_MASK_BIT 8'hB0
`define IGS_OFS_STATUS 8'hB4

// Source mask fields
`define IGS_BIT_GLOBAL 7
`define IGS_BIT_TIMER2 5
`define IGS_BIT_SERIAL 4
`define IGS_BIT_TIMER1 3
`define IGS_BIT_EXT1 2
`define IGS_BIT_TIMER0 1
`define IGS_BIT_EXT0 0
`define IGS_MASK_IMPL 8'hBF
`define IGS_MASK_RST 8'h00

// Power control fields
`define IGS_BIT_DOZE 0
`define IGS_BIT_DEEP 1
`define IGS_BIT_UFLAG0 2
`define IGS_BIT_UFLAG1 3
`define IGS_PWR_RST 4'h0

// Bit access register fields
`define IGS_BITOP_IDX_HI 2
`define IGS_BITOP_VAL 3

// Timing
`define IGS_CLK_PERIOD_NS 20
`define IGS_OSC_PER_MACH 12
`define IGS_RST_MACH_CYCLES 2
`define IGS_RST_HOLD_CYC (`IGS_RST_MACH_CYCLES * `IGS_OSC_PER_MACH)
`define IGS_SETTLE_TIME_NS 10000
`define IGS_SETTLE_CYC ((`IGS_SETTLE_TIME_NS + `IGS_CLK_PERIOD_NS - 1) / `IGS_CLK_PERIOD_NS)

`endif

// file: src/igs_pkg.sv
package igs_pkg;
    // Operating modes of the sleep controller
    typedef enum logic [2:0] {
        IGS_RUN,
        IGS_DOZE,
        IGS_DEEP,
        IGS_RESTART,
        IGS_SETTLE
    } igs_mode_t;
endpackage

// file: src/igs_pin_sync.sv
`timescale 1ns/100ps
// Three-stage pin synchroniser; the clean level moves only once stages two and three agree
module igs_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic s1_q; // Metastable stage, read only by s2_q
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            // Shift chain and agreement filter
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    s1_q <= RST_VAL[g];
                    s2_q <= RST_VAL[g];
                    s3_q <= RST_VAL[g];
                    lvl_q <= RST_VAL[g];
                end else begin
                    s1_q <= pin_i[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level_o[g] = lvl_q;
        end
    endgenerate
endmodule

// file: src/igs_sleep_ctrl.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "igs_regs.svh"
// What this block does
// - Global gate bit seven blocks every source, not owed wake interrupts
// - Per-source enable bits at fixed positions
// - Mask resets zero, bit and byte access
// - Doze-setting instruction completes, then Idle
// - Idle stops CPU clock, peripherals keep running
// - Idle keeps CPU state and port levels
// - Idle holds both bus strobes high
// - Enabled interrupt clears doze, ends Idle
// - Return resumes after the Idle instruction
// - Reset pin held 24 periods resets
// - Power-down stops the oscillator
// - Registers retain values through power-down
// - Only reset or enabled external pin wakes
// - Pin low restarts oscillator, release exits
// - Either pin restarts, first release exits
// - Return resumes after power-down instruction
// - Deep sleep bit enters, reset clears it
// - Two user flags freely read and written
module igs_sleep_ctrl (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic timer0_irq_i,
    input wire logic timer1_irq_i,
    input wire logic serial_irq_i,
    input wire logic timer2_irq_i,
    input wire logic wake_pin_0_n_i,
    input wire logic wake_pin_1_n_i,
    input wire logic reset_pin_i,
    input wire logic core_addr_latch_strobe_i,
    input wire logic core_program_fetch_strobe_i,
    input wire logic irq_ack_i,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_run_o,
    output logic port_hold_o,
    output logic addr_latch_strobe_o,
    output logic program_fetch_strobe_o,
    output logic irq_req_o,
    output logic [2:0] irq_id_o
);
    // Reset pin and wake pins arrive from the board
    logic [2:0] pin_lvl; // {reset pin, wake 1 level, wake 0 level}
    logic rst_cnt_hit;
    logic soft_rst;
    logic [4:0] rst_cnt_q; // Reset pin hold counter
    logic [7:0] mask_q; // Source mask register
    logic [7:0] mask_d;
    logic doze_q; // Power control bits
    logic deep_q;
    logic [1:0] uflag_q;
    logic [1:0] wake_pend_q; // Wake interrupts still owed to the core
    logic [1:0] wake_seen_q; // Pins seen low during restart
    logic [9:0] settle_q; // Oscillator settle counter
    igs_pkg::igs_mode_t mode_q;
    igs_pkg::igs_mode_t mode_d;
    logic wait_q; // Bus answer state, high while idle
    logic [31:0] rdata_q;
    logic cpu_en_q;
    logic periph_en_q;
    logic osc_q;
    logic hold_q;
    logic ale_q;
    logic fetch_q;
    logic irq_q;
    logic [2:0] id_q;

    // Pin synchroniser; low-active wake pins idle high
    igs_pin_sync #(
        .WIDTH(3),
        .RST_VAL(3'h3)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({reset_pin_i, wake_pin_1_n_i, wake_pin_0_n_i}),
        .level_o(pin_lvl)
    );

    // The oscillator keeps running in Idle, so the pin is reset once it has been held high for 24 counted cycles
    assign rst_cnt_hit = (rst_cnt_q == 5'(`IGS_RST_HOLD_CYC));
    assign soft_rst = sys_rst_i | rst_cnt_hit;

    // Count cycles of the reset pin held high; saturates so reset holds on
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || !pin_lvl[2]) begin
            rst_cnt_q <= 5'h00;
        end else if (!rst_cnt_hit) begin
            rst_cnt_q <= rst_cnt_q + 5'h01;
        end
    end

    // Source activity, same bit order as the mask
    wire ext0_low = !pin_lvl[0];
    wire ext1_low = !pin_lvl[1];
    wire [5:0] src_active = {timer2_irq_i, serial_irq_i, timer1_irq_i,
                             ext1_low, timer0_irq_i, ext0_low};
    // Each source passes only with its own bit and the global gate
    wire [5:0] src_accept = src_active & mask_q[5:0] & {6{mask_q[`IGS_BIT_GLOBAL]}};
    wire any_accept = |src_accept;
    // Only the external pins may wake from power-down
    wire [1:0] wake_en = {mask_q[`IGS_BIT_EXT1], mask_q[`IGS_BIT_EXT0]}
                         & {2{mask_q[`IGS_BIT_GLOBAL]}};
    wire [1:0] wake_low = {ext1_low, ext0_low} & wake_en;
    // Exit when a pin seen low has been released
    wire wake_release = |(wake_seen_q & ~{ext1_low, ext0_low});
    wire settle_done = (settle_q == 10'(`IGS_SETTLE_CYC - 1));

    // Bus decode; a request is taken once, on the edge where waitrequest is low
    wire bus_req = avs_read_i | avs_write_i;
    wire bus_take = bus_req & ~wait_q;
    wire wr_lane0 = avs_write_i & bus_take & avs_byteenable_i[0];
    wire hit_mask = (avs_address_i == `IGS_OFS_SRC_MASK);
    wire hit_pwr = (avs_address_i == `IGS_OFS_PWR_CTRL);
    wire hit_bit = (avs_address_i == `IGS_OFS_MASK_BIT);
    wire hit_stat = (avs_address_i == `IGS_OFS_STATUS);
    wire wr_mask = wr_lane0 & hit_mask;
    wire wr_pwr = wr_lane0 & hit_pwr;
    wire wr_bit = wr_lane0 & hit_bit;

    // Single-bit access to the mask
    wire [7:0] bit_sel = 8'h01 << avs_writedata_i[`IGS_BITOP_IDX_HI:0];
    wire [7:0] bit_new = avs_writedata_i[`IGS_BITOP_VAL] ? (mask_q | bit_sel)
                                                         : (mask_q & ~bit_sel);
    // Reserved bit six is never stored
    assign mask_d = wr_mask ? (avs_writedata_i[7:0] & `IGS_MASK_IMPL)
                  : wr_bit ? (bit_new & `IGS_MASK_IMPL)
                  : mask_q;

    // Read multiplexer; unmapped addresses read zero
    wire [31:0] rd_mux = hit_mask ? {24'h000000, mask_q}
                       : hit_pwr ? {28'h0000000, uflag_q, deep_q, doze_q}
                       : hit_stat ? {24'h000000, wake_pend_q, wake_seen_q,
                                     1'b0, 3'(mode_q)}
                       : 32'h00000000;

    // Bus answer: one wait cycle, then waitrequest low for one cycle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else if (bus_req && wait_q) begin
            wait_q <= 1'b0;
            rdata_q <= rd_mux;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Source mask; kept through both sleep modes
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst) begin
            mask_q <= `IGS_MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Power control bits; hardware clears doze and deep on wake or reset
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst) begin
            {uflag_q, deep_q, doze_q} <= `IGS_PWR_RST;
        end else begin
            if (wr_pwr) begin
                uflag_q <= {avs_writedata_i[`IGS_BIT_UFLAG1],
                            avs_writedata_i[`IGS_BIT_UFLAG0]};
            end
            if (mode_q == igs_pkg::IGS_DOZE && any_accept) begin
                doze_q <= 1'b0;
            end else if (wr_pwr) begin
                doze_q <= avs_writedata_i[`IGS_BIT_DOZE];
            end
            if (mode_q == igs_pkg::IGS_SETTLE && settle_done) begin
                deep_q <= 1'b0;
            end else if (wr_pwr) begin
                deep_q <= avs_writedata_i[`IGS_BIT_DEEP];
            end
        end
    end

    // Mode sequencing; deep sleep wins if both bits are written together
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            igs_pkg::IGS_RUN: begin
                // The writing instruction has completed when its write lands
                if (deep_q) begin
                    mode_d = igs_pkg::IGS_DEEP;
                end else if (doze_q) begin
                    mode_d = igs_pkg::IGS_DOZE;
                end
            end
            igs_pkg::IGS_DOZE: begin
                if (any_accept) begin
                    mode_d = igs_pkg::IGS_RUN;
                end
            end
            igs_pkg::IGS_DEEP: begin
                if (|wake_low) begin
                    mode_d = igs_pkg::IGS_RESTART;
                end
            end
            igs_pkg::IGS_RESTART: begin
                if (wake_release) begin
                    mode_d = igs_pkg::IGS_SETTLE;
                end
            end
            igs_pkg::IGS_SETTLE: begin
                if (settle_done) begin
                    mode_d = igs_pkg::IGS_RUN;
                end
            end
            default: begin
                mode_d = igs_pkg::IGS_RUN;
            end
        endcase
    end

    // Mode register; any reset returns to run
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst) begin
            mode_q <= igs_pkg::IGS_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Settle counter runs only while settling
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst || mode_q != igs_pkg::IGS_SETTLE) begin
            settle_q <= 10'h000;
        end else if (!settle_done) begin
            settle_q <= settle_q + 10'h001;
        end
    end

    // Remember which pins went low; each owes one interrupt after exit
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst) begin
            wake_seen_q <= 2'h0;
            wake_pend_q <= 2'h0;
        end else begin
            if (mode_q == igs_pkg::IGS_DEEP || mode_q == igs_pkg::IGS_RESTART) begin
                wake_seen_q <= wake_seen_q | wake_low;
            end else if (mode_q == igs_pkg::IGS_RUN) begin
                wake_seen_q <= 2'h0;
            end
            // A new wake beats an acknowledge in the same cycle
            if (mode_q == igs_pkg::IGS_SETTLE && settle_done) begin
                wake_pend_q <= wake_seen_q;
            end else if (irq_ack_i && irq_q) begin
                // Only an acknowledged wake id clears its own owed interrupt
                wake_pend_q <= wake_pend_q & ~{id_q == 3'h2, id_q == 3'h0};
            end
        end
    end

    // Highest priority request: ext0 first, then by bit order
    wire [5:0] req_vec = src_accept | {3'h0, wake_pend_q[1], 1'b0, wake_pend_q[0]};
    wire [2:0] req_id = req_vec[0] ? 3'h0 : req_vec[1] ? 3'h1 : req_vec[2] ? 3'h2
                      : req_vec[3] ? 3'h3 : req_vec[4] ? 3'h4 : 3'h5;
    wire run_next = (mode_d == igs_pkg::IGS_RUN);
    wire stop_next = (mode_d == igs_pkg::IGS_DEEP);

    // Clock gating and pin control follow the next mode, so they move with it
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst) begin
            cpu_en_q <= 1'b1;
            periph_en_q <= 1'b1;
            osc_q <= 1'b1;
            hold_q <= 1'b0;
        end else begin
            cpu_en_q <= run_next;
            periph_en_q <= !stop_next && mode_d != igs_pkg::IGS_RESTART;
            osc_q <= !stop_next;
            hold_q <= !run_next;
        end
    end

    // Strobes pass through in run, sit high in any sleep mode
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst) begin
            ale_q <= 1'b1;
            fetch_q <= 1'b1;
        end else begin
            ale_q <= run_next ? core_addr_latch_strobe_i : 1'b1;
            fetch_q <= run_next ? core_program_fetch_strobe_i : 1'b1;
        end
    end

    // The core is frozen, not reset, so its return address is the next one
    always_ff @(posedge ref_clk_i) begin
        if (soft_rst) begin
            irq_q <= 1'b0;
            id_q <= 3'h0;
        end else begin
            irq_q <= run_next && (|req_vec);
            id_q <= req_id;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;
    assign cpu_clk_en_o = cpu_en_q;
    assign periph_clk_en_o = periph_en_q;
    assign osc_run_o = osc_q;
    assign port_hold_o = hold_q;
    assign addr_latch_strobe_o = ale_q;
    assign program_fetch_strobe_o = fetch_q;
    assign irq_req_o = irq_q;
    assign irq_id_o = id_q;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (soft_rst);

    a_global_gate_off: assert property (
        (!mask_q[`IGS_BIT_GLOBAL] && wake_pend_q == 2'h0) |=> !irq_req_o)
        else $error("interrupt raised with global gate clear");
    a_timer2_enable: assert property (
        (mode_q == igs_pkg::IGS_RUN && !deep_q && !doze_q && timer2_irq_i
         && mask_q[`IGS_BIT_TIMER2] && mask_q[`IGS_BIT_GLOBAL]) |=> irq_req_o)
        else $error("enabled timer2 source not raised");
    a_mask_reserved: assert property (
        mask_q[6] == 1'b0)
        else $error("reserved mask bit stored");
    a_doze_entry: assert property (
        ($rose(doze_q) && !deep_q) |=> !cpu_clk_en_o && port_hold_o)
        else $error("cpu clock not stopped after doze write");
    a_doze_clocks: assert property (
        (mode_q == igs_pkg::IGS_DOZE)[*2] |-> periph_clk_en_o && !cpu_clk_en_o)
        else $error("clock gating wrong in idle");
    a_doze_strobes: assert property (
        (mode_q == igs_pkg::IGS_DOZE)[*2] |-> addr_latch_strobe_o && program_fetch_strobe_o)
        else $error("strobes not high in idle");
    a_doze_wake: assert property (
        (mode_q == igs_pkg::IGS_DOZE && any_accept) |=>
            mode_q == igs_pkg::IGS_RUN && !doze_q && irq_req_o)
        else $error("idle not ended by enabled interrupt");
    a_deep_osc_off: assert property (
        (mode_q == igs_pkg::IGS_DEEP)[*2] |-> !osc_run_o)
        else $error("oscillator running in power-down");
    a_restart_osc: assert property (
        (mode_q == igs_pkg::IGS_DEEP && |wake_low) |=> ##1 osc_run_o)
        else $error("oscillator not restarted by wake pin");
    a_settle_hold: assert property (
        $rose(mode_q == igs_pkg::IGS_SETTLE) |-> (mode_q == igs_pkg::IGS_SETTLE)[*8])
        else $error("settle period cut short");
    a_settle_exit: assert property (
        (mode_q == igs_pkg::IGS_SETTLE && settle_done) |=> !deep_q && cpu_clk_en_o)
        else $error("deep sleep bit not cleared on exit");
endmodule

// file: test/igs_pin_model.sv
`timescale 1ns/100ps
// Board side: two wake pins with pull-ups and the reset button
module igs_pin_model (
    input wire logic ref_clk_i,
    output logic wake_pin_0_n_o,
    output logic wake_pin_1_n_o,
    output logic reset_pin_o
);
    // Idle levels: pins released sit at their pull-up, reset inactive
    initial begin
        wake_pin_0_n_o = 1'b1;
        wake_pin_1_n_o = 1'b1;
        reset_pin_o = 1'b0;
    end

    // Pull one wake pin low; held long enough for the oscillator restart
    task automatic hold_wake(input int idx, input int cyc);
        @(posedge ref_clk_i);
        if (idx == 0) wake_pin_0_n_o <= 1'b0;
        else wake_pin_1_n_o <= 1'b0;
        repeat (cyc) @(posedge ref_clk_i);
        // Release back to the pull-up level; the other pin is left alone
        if (idx == 0) wake_pin_0_n_o <= 1'b1;
        else wake_pin_1_n_o <= 1'b1;
    endtask

    // Reset button; the caller picks a span beyond the two machine cycles
    task automatic hold_reset(input int cyc);
        @(posedge ref_clk_i);
        reset_pin_o <= 1'b1;
        repeat (cyc) @(posedge ref_clk_i);
        reset_pin_o <= 1'b0;
    endtask
endmodule

// file: test/tb.sv
`timescale 1ns/100ps
`include "igs_regs.svh"
module tb;
    logic clk, rst, rd, wr, ack, alat, pfs;
    logic [7:0] adr;
    logic [31:0] wd, rdat, q;
    logic [3:0] tirq; // timer0, timer1, serial, timer2
    logic w0_n, w1_n, rpin;
    logic wreq, cpu_en, per_en, osc, hold, alat_o, pfs_o, ireq;
    logic [2:0] iid;
    int error_cnt, comparisons, seed, i, k;
    logic [7:0] m;
    // Mask bit and interrupt id of each timer-side source
    int bitpos[4] = '{1, 3, 4, 5};

    igs_sleep_ctrl i_igs_sleep_ctrl (.ref_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .timer0_irq_i(tirq[0]),
        .timer1_irq_i(tirq[1]), .serial_irq_i(tirq[2]), .timer2_irq_i(tirq[3]),
        .wake_pin_0_n_i(w0_n), .wake_pin_1_n_i(w1_n), .reset_pin_i(rpin),
        .core_addr_latch_strobe_i(alat), .core_program_fetch_strobe_i(pfs), .irq_ack_i(ack),
        .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .osc_run_o(osc), .port_hold_o(hold),
        .addr_latch_strobe_o(alat_o), .program_fetch_strobe_o(pfs_o), .irq_req_o(ireq),
        .irq_id_o(iid));

    igs_pin_model i_igs_pin_model (.ref_clk_i(clk), .wake_pin_0_n_o(w0_n),
        .wake_pin_1_n_o(w1_n), .reset_pin_o(rpin));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // One comparison; prints and counts a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Avalon cycle: hold the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        if (n >= 50) error_cnt++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // Expected request from the gate bit and the source's own bit
    function automatic logic exp_req(input logic [7:0] msk, input int b);
        return msk[7] & msk[b];
    endfunction

    // Verdict
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    // Main sequence
    initial begin
        seed = 32'hca65;
        error_cnt = 0;
        comparisons = 0;
        rst = 1'b1;
        {rd, wr, ack, adr, wd, tirq} = '0;
        alat = 1'b0;
        pfs = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped place, strobes passed while running
        bus(0, `IGS_OFS_SRC_MASK, 0); chk(q, 0);
        bus(0, `IGS_OFS_PWR_CTRL, 0); chk(q, 0);
        bus(0, 8'h10, 0); chk(q, 0);
        chk({alat_o, pfs_o, cpu_en}, 3'b001);
        $display("test reset done");
        // Whole-byte mask write and bit access
        bus(1, `IGS_OFS_SRC_MASK, 32'hFF); bus(0, `IGS_OFS_SRC_MASK, 0); chk(q, 32'hBF);
        bus(1, `IGS_OFS_MASK_BIT, 32'h7); bus(0, `IGS_OFS_SRC_MASK, 0); chk(q, 32'h3F);
        // Gate and per-source enables, corner masks first then random
        for (i = 0; i < 12; i++) begin
            m = (i == 0) ? 8'h3F : (i == 1) ? 8'hBF : 8'($random(seed));
            k = i % 4;
            bus(1, `IGS_OFS_SRC_MASK, {24'h0, m & 8'hBF});
            @(posedge clk) tirq[k] <= 1'b1;
            repeat (4) @(posedge clk);
            chk(ireq, exp_req(m, bitpos[k]));
            if (exp_req(m, bitpos[k])) chk(iid, bitpos[k]);
            tirq[k] <= 1'b0;
            ack <= 1'b1;
            @(posedge clk) ack <= 1'b0;
            repeat (3) @(posedge clk);
        end
        $display("test gating done");
        // User flags
        bus(1, `IGS_OFS_PWR_CTRL, 32'hC); bus(0, `IGS_OFS_PWR_CTRL, 0); chk(q, 32'hC);
        bus(1, `IGS_OFS_PWR_CTRL, 32'h4); bus(0, `IGS_OFS_PWR_CTRL, 0); chk(q, 32'h4);
        // Idle: CPU stopped, peripherals run, strobes high, then timer wake
        bus(1, `IGS_OFS_SRC_MASK, 32'h82);
        bus(1, `IGS_OFS_PWR_CTRL, 32'h5);
        repeat (4) @(posedge clk);
        chk({cpu_en, per_en, osc}, 3'b011);
        chk(hold, 1'b1);
        chk({alat_o, pfs_o}, 2'b11);
        @(posedge clk) tirq[0] <= 1'b1;
        repeat (5) @(posedge clk);
        tirq[0] <= 1'b0;
        chk({cpu_en, hold}, 2'b10);
        bus(0, `IGS_OFS_PWR_CTRL, 0); chk(q, 32'h4);
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        $display("test idle done");
        // Power-down: non-wake sources and a disabled pin leave it asleep
        bus(1, `IGS_OFS_SRC_MASK, 32'h81);
        bus(1, `IGS_OFS_PWR_CTRL, 32'h2);
        repeat (4) @(posedge clk);
        chk({osc, cpu_en, per_en}, 3'b000);
        tirq[0] <= 1'b1;
        i_igs_pin_model.hold_wake(1, 20);
        tirq[0] <= 1'b0;
        repeat (8) @(posedge clk);
        chk(osc, 1'b0);
        // Enabled pin: low restarts, release starts the settle count
        i_igs_pin_model.hold_wake(0, 20);
        chk(osc, 1'b1);
        repeat (450) @(posedge clk);
        chk(cpu_en, 1'b0);
        for (k = 0; k < 200 && cpu_en !== 1'b1; k++) @(posedge clk);
        chk(cpu_en, 1'b1);
        // Release to run is sync lag plus the 500-cycle settle count
        chk(k >= 50 && k <= 62, 1'b1);
        repeat (2) @(posedge clk);
        chk({ireq, iid}, 4'h8);
        bus(0, `IGS_OFS_SRC_MASK, 0); chk(q, 32'h81);
        bus(0, `IGS_OFS_PWR_CTRL, 0); chk(q, 32'h0);
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        $display("test power-down done");
        // Reset pin ends Idle and clears the registers
        bus(1, `IGS_OFS_PWR_CTRL, 32'h9);
        i_igs_pin_model.hold_reset(32);
        repeat (8) @(posedge clk);
        chk(cpu_en, 1'b1);
        bus(0, `IGS_OFS_PWR_CTRL, 0); chk(q, 0);
        bus(0, `IGS_OFS_SRC_MASK, 0); chk(q, 0);
        $display("test reset pin done");
        // Both wake pins low: first release exits, ext0 served before ext1
        bus(1, `IGS_OFS_SRC_MASK, 32'h81);
        bus(1, `IGS_OFS_MASK_BIT, 32'hA); bus(0, `IGS_OFS_SRC_MASK, 0); chk(q, 32'h85);
        bus(1, `IGS_OFS_PWR_CTRL, 32'h2);
        repeat (4) @(posedge clk);
        fork
            i_igs_pin_model.hold_wake(1, 20);
            i_igs_pin_model.hold_wake(0, 60);
        join
        for (k = 0; k < 600 && cpu_en !== 1'b1; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk({ireq, iid}, 4'h8);
        bus(0, `IGS_OFS_STATUS, 0); chk(q, 32'hC0);
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        repeat (3) @(posedge clk);
        chk({ireq, iid}, 4'hA);
        ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        repeat (3) @(posedge clk);
        chk(ireq, 1'b0);
        $display("test two pins done");
        conclude();
    end
endmodule
